// ### design/rds_pkg.sv
// Constants shared by the reset delay sequencer.
// Assumes a 100 MHz reference that runs from power-up onward.
package rds_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS         = 10;
    localparam int POWER_ON_DELAY_NS     = 10000;
    localparam int STARTUP_REG_ON_NS     = 20000;
    localparam int STARTUP_REG_OFF_NS    = 64000000;
    localparam int INTERNAL_RESET_NS     = 20000;
    localparam int PLL_LOCK_TIME_NS      = 20000;
    localparam int MONITOR_HOLDOFF_NS    = 100000;
    // Least times round up
    localparam int POWER_ON_DELAY_CYC    = (POWER_ON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STARTUP_REG_ON_CYC    = (STARTUP_REG_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STARTUP_REG_OFF_CYC   = (STARTUP_REG_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INTERNAL_RESET_CYC    = (INTERNAL_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PLL_LOCK_TIME_CYC     = (PLL_LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MONITOR_HOLDOFF_CYC   = (MONITOR_HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_STARTUP_PERIODS   = 1024;

    // ==========================================================
    // Counters and encodings
    typedef logic [22:0] rds_cnt_type;
    typedef logic [9:0]  rds_ost_type;
    typedef logic [2:0]  rds_osc_type;
    localparam rds_osc_type OSC_FAST_RC     = 3'h0;
    localparam rds_osc_type OSC_FAST_RC_PLL = 3'h1;
    localparam rds_osc_type OSC_PRIMARY     = 3'h2;
    localparam rds_osc_type OSC_PRIMARY_PLL = 3'h3;
    localparam rds_osc_type OSC_SECONDARY   = 3'h4;

    // Reset source vector positions
    localparam int EV_POR    = 0;
    localparam int EV_BOR    = 1;
    localparam int EV_PIN    = 2;
    localparam int EV_WDT    = 3;
    localparam int EV_SW     = 4;
    localparam int EV_ILLOP  = 5;
    localparam int EV_UNINIT = 6;
    localparam int EV_TRAP   = 7;

    // Cause register fields and oscillator control fields
    localparam int CAUSE_POR    = 0;
    localparam int CAUSE_BOR    = 1;
    localparam int CAUSE_WDT    = 4;
    localparam int CAUSE_SW     = 6;
    localparam int CAUSE_PIN    = 7;
    localparam int CAUSE_ILLOP  = 14;
    localparam int CAUSE_TRAP   = 15;
    localparam int OSCCTL_CUR_LSB = 12;
    localparam int OSCCTL_NEW_LSB = 8;
    localparam logic [15:0] CAUSE_RESET_VAL  = 16'h0003;
    localparam logic [15:0] OSCCTL_RESET_VAL = 16'h0000;

    typedef enum logic [2:0] {
        PH_POWER_ON = 3'b000,
        PH_STARTUP  = 3'b001,
        PH_INTERNAL = 3'b010,
        PH_WAKE     = 3'b011,
        PH_RUN      = 3'b100
    } rds_phase_type;
endpackage : rds_pkg

// ### design/rds_sequencer.sv
// Reset delay sequencer: holds system reset, qualifies the clock, releases execution.
// Assumes reset source pins are asynchronous; config, wake and cause write are on REF_CLK_I.
`timescale 1ns/10ps

// Functional notes
// - Power resets use initial select, others current
// - Release system reset after all reset delays expire
// - Clock qualification runs alongside reset delay
// - Power-on adds power-on delay; brown-out skips
// - Startup delay depends on regulator enable
// - Wake with regulator on inserts startup delay
// - Other resets hold internal reset time only
// - Count 1024 oscillator periods for crystal sources
// - Wait PLL lock time after oscillator count
// - Monitor hold-off after power-reset release for crystal/PLL
// - Monitor never checks before hold-off expires
// - No execution before clock is released
// - Missing clock falls back to fast RC, trap
// - Only cause and oscillator control vary
// - Oscillator control reset value follows source
// - Without switching, always use initial select
// - Software may set and clear cause flags
module rds_sequencer #(
    parameter int STARTUP_REG_OFF_CYC = rds_pkg::STARTUP_REG_OFF_CYC,
    parameter int MONITOR_HOLDOFF_CYC = rds_pkg::MONITOR_HOLDOFF_CYC
) (
    input  wire logic        REF_CLK_I,        // 100 MHz reference
    input  wire logic        SRST_I,           // Sync reset, acts as power-on
    input  wire logic [7:0]  RST_SRC_I,        // Reset source levels, async
    input  wire logic        OSC_I,            // Oscillator output, async
    input  wire logic        OSC_VALID_I,      // Clock present, async
    input  wire logic        WAKE_I,           // Wake from power-down pulse
    input  wire logic        REG_EN_I,         // On-chip regulator enabled
    input  wire logic        CLKSW_EN_I,       // Clock switching enabled
    input  wire logic        PRI_XTAL_I,       // Primary source is a crystal
    input  wire logic        MONITOR_EN_I,     // Fail-safe monitor enabled
    input  wire logic [2:0]  INIT_OSC_SEL_I,   // Initial oscillator select
    input  wire logic [2:0]  CUR_OSC_SEL_I,    // Current oscillator select
    input  wire logic        CAUSE_WE_I,       // Cause register write strobe
    input  wire logic [15:0] CAUSE_WDATA_I,    // Cause register write data
    output logic             SYSTEM_RESET_O,   // System reset, high active
    output logic             CLK_VALID_O,      // Clock released to system
    output logic             EXEC_EN_O,        // Core may execute
    output logic [2:0]       CLK_SEL_O,        // Selected clock source
    output logic             MONITOR_ACTIVE_O, // Monitor is checking
    output logic             OSC_FAIL_TRAP_O,  // Oscillator fail trap pulse
    output logic [15:0]      OSC_CTRL_O,       // Oscillator control reset value
    output logic [15:0]      RESET_CAUSE_O     // Reset cause flags
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0]            src_s1;
        logic [7:0]            src_s2;
        logic                  osc_s1;
        logic                  osc_s2;
        logic                  osc_s3;
        logic                  valid_s1;
        logic                  valid_s2;
        rds_pkg::rds_phase_type phase;
        rds_pkg::rds_cnt_type  dly;
        logic                  from_power;
        logic                  arm;
        rds_pkg::rds_osc_type  sel;
        rds_pkg::rds_ost_type  osc_startup_timer;
        logic                  ost_done;
        rds_pkg::rds_cnt_type  pll;
        rds_pkg::rds_cnt_type  hold;
        logic                  hold_on;
        logic                  system_reset;
        logic                  clk_ok;
        logic                  exec;
        logic                  mon;
        logic                  trap;
        logic [15:0]           osc_ctrl;
        logic [15:0]           cause;
    } rds_state_type;

    rds_state_type st_r;
    rds_state_type st_nxt;

    function automatic logic needs_ost(input rds_pkg::rds_osc_type s, input logic xtal);
        needs_ost = ((s == rds_pkg::OSC_PRIMARY || s == rds_pkg::OSC_PRIMARY_PLL) && xtal)
                    || s == rds_pkg::OSC_SECONDARY;
    endfunction : needs_ost

    function automatic logic needs_pll(input rds_pkg::rds_osc_type s);
        needs_pll = (s == rds_pkg::OSC_FAST_RC_PLL || s == rds_pkg::OSC_PRIMARY_PLL);
    endfunction : needs_pll

    logic any_other;
    logic osc_edge;
    assign any_other = |st_r.src_s2[7:2];
    // Rising edges only, so each step is one full oscillator period
    assign osc_edge  = st_r.osc_s2 & ~st_r.osc_s3;

    // ==========================================================
    // Next state
    always_comb
    begin
        st_nxt          = st_r;
        st_nxt.src_s1   = RST_SRC_I;
        st_nxt.src_s2   = st_r.src_s1;
        st_nxt.osc_s1   = OSC_I;
        st_nxt.osc_s2   = st_r.osc_s1;
        st_nxt.osc_s3   = st_r.osc_s2;
        st_nxt.valid_s1 = OSC_VALID_I;
        st_nxt.valid_s2 = st_r.valid_s1;
        st_nxt.trap     = 1'b0;
        st_nxt.arm      = 1'b0;

        // Reset delay phases
        unique case (st_r.phase)
            rds_pkg::PH_POWER_ON:
            begin
                if (st_r.dly == '0)
                begin
                    st_nxt.phase = rds_pkg::PH_STARTUP;
                    st_nxt.dly   = REG_EN_I ?
                        rds_pkg::rds_cnt_type'(rds_pkg::STARTUP_REG_ON_CYC - 1) :
                        rds_pkg::rds_cnt_type'(STARTUP_REG_OFF_CYC - 1);
                end
                else
                    st_nxt.dly = st_r.dly - 1'b1;
            end
            rds_pkg::PH_STARTUP:
            begin
                if (st_r.dly == '0)
                begin
                    st_nxt.phase = rds_pkg::PH_INTERNAL;
                    st_nxt.dly   = rds_pkg::rds_cnt_type'(rds_pkg::INTERNAL_RESET_CYC - 1);
                end
                else
                    st_nxt.dly = st_r.dly - 1'b1;
            end
            rds_pkg::PH_INTERNAL:
            begin
                if (st_r.dly == '0)
                begin
                    st_nxt.phase   = rds_pkg::PH_RUN;
                    // Hold-off only for crystal or PLL after a power reset
                    st_nxt.hold_on = 1'b1;
                    st_nxt.hold    = (st_r.from_power && (needs_ost(st_r.sel, PRI_XTAL_I)
                                      || needs_pll(st_r.sel))) ?
                                     rds_pkg::rds_cnt_type'(MONITOR_HOLDOFF_CYC - 1) : '0;
                end
                else
                    st_nxt.dly = st_r.dly - 1'b1;
            end
            rds_pkg::PH_RUN:
            begin
                if (WAKE_I && REG_EN_I)
                begin
                    st_nxt.phase = rds_pkg::PH_WAKE;
                    st_nxt.dly   = rds_pkg::rds_cnt_type'(rds_pkg::STARTUP_REG_ON_CYC - 1);
                end
            end
            rds_pkg::PH_WAKE:
            begin
                if (st_r.dly == '0)
                    st_nxt.phase = rds_pkg::PH_RUN;
                else
                    st_nxt.dly = st_r.dly - 1'b1;
            end
            default:
            begin
                st_nxt.phase = rds_pkg::PH_POWER_ON;
                st_nxt.dly   = rds_pkg::rds_cnt_type'(rds_pkg::POWER_ON_DELAY_CYC - 1);
            end
        endcase

        // Clock qualification, independent of the reset phase
        if (!st_r.ost_done)
        begin
            if (osc_edge)
            begin
                st_nxt.osc_startup_timer = st_r.osc_startup_timer + 1'b1;
                if (st_r.osc_startup_timer == rds_pkg::rds_ost_type'(rds_pkg::OSC_STARTUP_PERIODS - 1))
                    st_nxt.ost_done = 1'b1;
            end
        end
        else if (st_r.pll != '0)
            st_nxt.pll = st_r.pll - 1'b1;
        st_nxt.clk_ok = st_r.clk_ok || (st_r.ost_done && st_r.pll == '0);

        // Monitor hold-off, then one check when monitoring starts
        if (st_r.hold_on)
        begin
            if (st_r.hold == '0)
            begin
                st_nxt.hold_on = 1'b0;
                st_nxt.mon     = MONITOR_EN_I;
                if (MONITOR_EN_I && !st_r.valid_s2)
                begin
                    st_nxt.sel      = rds_pkg::OSC_FAST_RC;
                    st_nxt.trap     = 1'b1;
                    st_nxt.ost_done = 1'b1;
                    st_nxt.pll      = '0;
                    st_nxt.clk_ok   = 1'b1;
                end
            end
            else
                st_nxt.hold = st_r.hold - 1'b1;
        end

        // Reset sources override, power-on first
        if (st_r.src_s2[rds_pkg::EV_POR] || st_r.src_s2[rds_pkg::EV_BOR] || any_other)
        begin
            st_nxt.hold_on = 1'b0;
            st_nxt.mon     = 1'b0;
            st_nxt.trap    = 1'b0;
            if (st_r.src_s2[rds_pkg::EV_POR])
            begin
                st_nxt.phase = rds_pkg::PH_POWER_ON;
                st_nxt.dly   = rds_pkg::rds_cnt_type'(rds_pkg::POWER_ON_DELAY_CYC - 1);
            end
            else if (st_r.src_s2[rds_pkg::EV_BOR])
            begin
                st_nxt.phase = rds_pkg::PH_STARTUP;
                st_nxt.dly   = REG_EN_I ?
                    rds_pkg::rds_cnt_type'(rds_pkg::STARTUP_REG_ON_CYC - 1) :
                    rds_pkg::rds_cnt_type'(STARTUP_REG_OFF_CYC - 1);
            end
            else
            begin
                st_nxt.phase = rds_pkg::PH_INTERNAL;
                st_nxt.dly   = rds_pkg::rds_cnt_type'(rds_pkg::INTERNAL_RESET_CYC - 1);
            end
            st_nxt.from_power = st_r.src_s2[rds_pkg::EV_POR] || st_r.src_s2[rds_pkg::EV_BOR];
            st_nxt.arm        = st_nxt.from_power;
            st_nxt.sel        = (CLKSW_EN_I && !st_nxt.from_power) ?
                                CUR_OSC_SEL_I : INIT_OSC_SEL_I;
        end

        // Re-arm qualification; counts run while reset delays proceed
        if (st_r.arm)
        begin
            st_nxt.osc_startup_timer      = '0;
            st_nxt.ost_done = !needs_ost(st_r.sel, PRI_XTAL_I);
            st_nxt.pll      = needs_pll(st_r.sel) ?
                              rds_pkg::rds_cnt_type'(rds_pkg::PLL_LOCK_TIME_CYC) : '0;
            st_nxt.clk_ok   = 1'b0;
        end

        st_nxt.system_reset = !(st_nxt.phase == rds_pkg::PH_RUN || st_nxt.phase == rds_pkg::PH_WAKE);
        // Wake holds execution but not the system reset
        st_nxt.exec   = !st_r.system_reset && st_r.clk_ok && st_r.phase == rds_pkg::PH_RUN;

        // Only these two registers depend on the reset kind
        st_nxt.osc_ctrl = rds_pkg::OSCCTL_RESET_VAL;
        st_nxt.osc_ctrl[rds_pkg::OSCCTL_CUR_LSB +: 3] = st_nxt.sel;
        st_nxt.osc_ctrl[rds_pkg::OSCCTL_NEW_LSB +: 3] = st_nxt.sel;

        // Cause flags: software write first, hardware set wins
        if (CAUSE_WE_I)
            st_nxt.cause = CAUSE_WDATA_I;
        if (st_r.src_s2[rds_pkg::EV_POR])
            st_nxt.cause = rds_pkg::CAUSE_RESET_VAL;
        else if (st_r.src_s2[rds_pkg::EV_BOR])
        begin
            st_nxt.cause = st_nxt.cause & (16'h0001 << rds_pkg::CAUSE_PIN);
            st_nxt.cause[rds_pkg::CAUSE_BOR] = 1'b1;
        end
        if (st_r.src_s2[rds_pkg::EV_PIN])
            st_nxt.cause[rds_pkg::CAUSE_PIN] = 1'b1;
        if (st_r.src_s2[rds_pkg::EV_WDT])
            st_nxt.cause[rds_pkg::CAUSE_WDT] = 1'b1;
        if (st_r.src_s2[rds_pkg::EV_SW])
            st_nxt.cause[rds_pkg::CAUSE_SW] = 1'b1;
        if (st_r.src_s2[rds_pkg::EV_ILLOP] || st_r.src_s2[rds_pkg::EV_UNINIT])
            st_nxt.cause[rds_pkg::CAUSE_ILLOP] = 1'b1;
        if (st_r.src_s2[rds_pkg::EV_TRAP])
            st_nxt.cause[rds_pkg::CAUSE_TRAP] = 1'b1;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            st_r          <= '0;
            st_r.phase    <= rds_pkg::PH_POWER_ON;
            st_r.dly      <= rds_pkg::rds_cnt_type'(rds_pkg::POWER_ON_DELAY_CYC - 1);
            st_r.from_power <= 1'b1;
            st_r.system_reset   <= 1'b1;
            st_r.cause    <= rds_pkg::CAUSE_RESET_VAL;
            st_r.osc_ctrl <= rds_pkg::OSCCTL_RESET_VAL;
        end
        else
            st_r <= st_nxt;
    end

    assign SYSTEM_RESET_O   = st_r.system_reset;
    assign CLK_VALID_O      = st_r.clk_ok;
    assign EXEC_EN_O        = st_r.exec;
    assign CLK_SEL_O        = st_r.sel;
    assign MONITOR_ACTIVE_O = st_r.mon;
    assign OSC_FAIL_TRAP_O  = st_r.trap;
    assign OSC_CTRL_O       = st_r.osc_ctrl;
    assign RESET_CAUSE_O    = st_r.cause;

    // ==========================================================
    // Assertions
    a_exec_needs_clk: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        EXEC_EN_O |-> $past(st_r.clk_ok) && !$past(st_r.system_reset))
        else $error("execution enabled without released clock");

    a_release_after_isr: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        $fell(SYSTEM_RESET_O) |-> $past(st_r.phase) == rds_pkg::PH_INTERNAL && $past(st_r.dly) == '0)
        else $error("system reset released early");

    a_por_to_startup: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        (st_r.phase == rds_pkg::PH_POWER_ON && st_r.dly == '0 && st_r.src_s2 == '0 && REG_EN_I)
        |=> st_r.phase == rds_pkg::PH_STARTUP
            && st_r.dly == rds_pkg::rds_cnt_type'(rds_pkg::STARTUP_REG_ON_CYC - 1))
        else $error("startup delay not loaded");

    a_pin_internal: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        (st_r.src_s2 == (8'h01 << rds_pkg::EV_PIN))
        |=> st_r.phase == rds_pkg::PH_INTERNAL && SYSTEM_RESET_O
            && st_r.dly == rds_pkg::rds_cnt_type'(rds_pkg::INTERNAL_RESET_CYC - 1))
        else $error("pin reset not internal delay");

    a_sel_by_kind: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        (st_r.src_s2 == (8'h01 << rds_pkg::EV_WDT) && CLKSW_EN_I) |=> CLK_SEL_O == $past(CUR_OSC_SEL_I))
        else $error("watchdog reset used wrong select");

    a_sel_power: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        (st_r.src_s2[rds_pkg::EV_POR] || !CLKSW_EN_I && any_other) |=> CLK_SEL_O == $past(INIT_OSC_SEL_I))
        else $error("initial select not used");

    a_holdoff_first: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        $rose(MONITOR_ACTIVE_O) |-> $past(st_r.hold_on) && $past(st_r.hold) == '0)
        else $error("monitor started before hold-off");

    a_trap_fallback: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        OSC_FAIL_TRAP_O |-> CLK_SEL_O == rds_pkg::OSC_FAST_RC && CLK_VALID_O ##1 !OSC_FAIL_TRAP_O)
        else $error("fallback or trap wrong");

    a_ost_gates_clk: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        $rose(CLK_VALID_O) && !OSC_FAIL_TRAP_O |-> $past(st_r.ost_done) && $past(st_r.pll) == '0)
        else $error("clock released before count");

    a_osc_ctrl_sel: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        OSC_CTRL_O[rds_pkg::OSCCTL_CUR_LSB +: 3] == CLK_SEL_O)
        else $error("oscillator control value mismatch");

    a_cause_set_wins: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        (st_r.src_s2[rds_pkg::EV_WDT] && CAUSE_WE_I) |=> RESET_CAUSE_O[rds_pkg::CAUSE_WDT])
        else $error("cause flag set lost to write");

endmodule : rds_sequencer

// ### tb/rds_osc_model.sv
// Behavioural oscillator that stands on the far side of the reset delay sequencer.
// Assumes it is clocked by the same reference as the sequencer; rising edges are counted there.
`timescale 1ns/10ps

module rds_osc_model (
    input  wire logic       clk_i,   // Reference clock
    input  wire logic       run_i,   // Oscillator running
    input  wire logic [3:0] half_i,  // Reference cycles per toggle
    output logic            osc_o,   // Oscillator waveform
    output logic            valid_o  // Clock present
);
    logic [3:0] cnt_r = 4'h0;

    initial osc_o = 1'b0;

    // =========================================================
    // Waveform
    // A stopped crystal holds its level, so no toggle is seen
    always @(posedge clk_i)
    begin
        cnt_r <= (run_i && cnt_r + 4'h1 < half_i) ? cnt_r + 4'h1 : 4'h0;
        if (run_i && cnt_r + 4'h1 >= half_i)
            osc_o <= ~osc_o;
    end

    assign valid_o = run_i;
endmodule : rds_osc_model

// ### tb/test_rds_sequencer.sv
// Self-checking bench for the reset delay sequencer with an oscillator model.
// Assumes short parameter values for the long start-up and hold-off counts.
`timescale 1ns/10ps

module test_rds_sequencer;
    localparam int TP = rds_pkg::POWER_ON_DELAY_CYC;
    localparam int TS = rds_pkg::STARTUP_REG_ON_CYC;
    localparam int TR = rds_pkg::INTERNAL_RESET_CYC;
    localparam int OFF = 50;
    localparam int HOLD = 20;
    typedef struct {int src; int reg_en; int clksw; int dly; logic [2:0] sel;
        logic [15:0] cause;} rds_row_type;
    logic REF_CLK_I = 0, SRST_I = 1, WAKE_I = 0, REG_EN_I = 1, CLKSW_EN_I = 1;
    logic PRI_XTAL_I = 1, MONITOR_EN_I = 0, CAUSE_WE_I = 0, osc_run = 1;
    logic [7:0]  RST_SRC_I = 0;
    logic [2:0]  INIT_OSC_SEL_I = 0, CUR_OSC_SEL_I = 4, CLK_SEL_O;
    logic [15:0] CAUSE_WDATA_I = 0, OSC_CTRL_O, RESET_CAUSE_O;
    logic [3:0]  osc_half = 1;
    logic OSC_I, OSC_VALID_I, SYSTEM_RESET_O, CLK_VALID_O, EXEC_EN_O;
    logic MONITOR_ACTIVE_O, OSC_FAIL_TRAP_O, bad;
    int errors = 0, tests_run = 0, cyc = 0, n;
    rds_row_type r;
    // Power resets first so the clock is qualified before the others run
    rds_row_type rows [11] = '{
        '{0, 1, 1, TP + TS + TR + 2, 3'h0, 16'h0003}, '{0, 0, 1, TP + OFF + TR + 2, 3'h0, 16'h0003},
        '{1, 1, 1, TS + TR + 2, 3'h0, 16'h0002}, '{1, 0, 1, OFF + TR + 2, 3'h0, 16'h0002},
        '{2, 1, 1, TR + 2, 3'h4, 16'h0080}, '{2, 1, 0, TR + 2, 3'h0, 16'h0080},
        '{3, 1, 1, TR + 2, 3'h4, 16'h0010}, '{4, 1, 1, TR + 2, 3'h4, 16'h0040},
        '{5, 1, 1, TR + 2, 3'h4, 16'h4000}, '{6, 1, 1, TR + 2, 3'h4, 16'h4000},
        '{7, 1, 1, TR + 2, 3'h4, 16'h8000}};

    rds_sequencer #(.STARTUP_REG_OFF_CYC(OFF), .MONITOR_HOLDOFF_CYC(HOLD)) dut (
        .REF_CLK_I(REF_CLK_I), .SRST_I(SRST_I), .RST_SRC_I(RST_SRC_I), .OSC_I(OSC_I),
        .OSC_VALID_I(OSC_VALID_I), .WAKE_I(WAKE_I), .REG_EN_I(REG_EN_I),
        .CLKSW_EN_I(CLKSW_EN_I), .PRI_XTAL_I(PRI_XTAL_I), .MONITOR_EN_I(MONITOR_EN_I),
        .INIT_OSC_SEL_I(INIT_OSC_SEL_I), .CUR_OSC_SEL_I(CUR_OSC_SEL_I),
        .CAUSE_WE_I(CAUSE_WE_I), .CAUSE_WDATA_I(CAUSE_WDATA_I),
        .SYSTEM_RESET_O(SYSTEM_RESET_O), .CLK_VALID_O(CLK_VALID_O), .EXEC_EN_O(EXEC_EN_O),
        .CLK_SEL_O(CLK_SEL_O), .MONITOR_ACTIVE_O(MONITOR_ACTIVE_O),
        .OSC_FAIL_TRAP_O(OSC_FAIL_TRAP_O), .OSC_CTRL_O(OSC_CTRL_O),
        .RESET_CAUSE_O(RESET_CAUSE_O));
    rds_osc_model osc (.clk_i(REF_CLK_I), .run_i(osc_run), .half_i(osc_half),
        .osc_o(OSC_I), .valid_o(OSC_VALID_I));

    // =========================================================
    // Clock, tasks and watchdog
    initial forever #5 REF_CLK_I = ~REF_CLK_I;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Sync stages leave a few cycles of slack on every count
    task automatic chk_time(input int got, input int exp, input int tol);
        tests_run++;
        if (got < exp - tol || got > exp + tol)
        begin
            errors++;
            $display("mismatch at %0t: got %h cycles expected %h", $time, got, exp);
        end
    endtask : chk_time

    task automatic cy(input int k);
        repeat (k) @(negedge REF_CLK_I);
    endtask : cy

    task automatic fire(input int src);
        RST_SRC_I[src] = 1'b1;
        cy(4);
        RST_SRC_I[src] = 1'b0;
    endtask : fire

    task automatic wait_rel(output int c);
        c = 0;
        while (SYSTEM_RESET_O !== 1'b0 && c < 20000)
        begin
            cy(1);
            c++;
        end
    endtask : wait_rel

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    always @(posedge REF_CLK_I)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            errors++;
            close_out();
        end
    end

    // =========================================================
    // Main sequence
    initial
    begin
        cy(6);
        chk({SYSTEM_RESET_O, EXEC_EN_O}, 16'h0002);
        chk(OSC_CTRL_O, 16'h0000);
        chk(RESET_CAUSE_O, 16'h0003);
        SRST_I = 1'b0;
        foreach (rows[i])
        begin
            r = rows[i];
            REG_EN_I = 1'(r.reg_en);
            CLKSW_EN_I = 1'(r.clksw);
            CAUSE_WE_I = 1'b1;
            cy(1);
            CAUSE_WE_I = 1'b0;
            cy(2);
            chk(RESET_CAUSE_O, 16'h0000);
            fire(r.src);
            chk({13'h0, CLK_SEL_O}, {13'h0, r.sel});
            wait_rel(n);
            chk_time(n, r.dly, 4);
            chk(RESET_CAUSE_O, r.cause);
            chk(OSC_CTRL_O, {1'b0, r.sel, 1'b0, r.sel, 8'h00});
            $display("row %0d done", i);
            cy(5);
        end
        // Crystal with PLL: qualification overlaps the reset delay
        REG_EN_I = 1'b1;
        INIT_OSC_SEL_I = rds_pkg::OSC_PRIMARY_PLL;
        MONITOR_EN_I = 1'b1;
        fire(0);
        wait_rel(n);
        chk(CLK_VALID_O, 1'b1);
        cy(1);
        chk(EXEC_EN_O, 1'b1);
        cy(HOLD / 2);
        chk(MONITOR_ACTIVE_O, 1'b0);
        cy(HOLD);
        chk({MONITOR_ACTIVE_O, CLK_SEL_O}, 16'h000b);
        $display("pll test done");
        // Slow crystal outlasts the reset delay: no execution yet
        REG_EN_I = 1'b0;
        INIT_OSC_SEL_I = rds_pkg::OSC_PRIMARY;
        MONITOR_EN_I = 1'b0;
        osc_half = 4'h4;
        fire(0);
        wait_rel(n);
        chk(CLK_VALID_O, 1'b0);
        n = 0;
        bad = 1'b0;
        while (CLK_VALID_O !== 1'b1 && n < 10000)
        begin
            bad = bad | (EXEC_EN_O !== 1'b0);
            cy(1);
            n++;
        end
        chk(bad, 1'b0);
        chk_time(n, 8 * rds_pkg::OSC_STARTUP_PERIODS - (TP + OFF + TR + 2), 12);
        cy(1);
        chk(EXEC_EN_O, 1'b1);
        $display("slow crystal test done");
        // Dead crystal with monitor on falls back to fast RC
        REG_EN_I = 1'b1;
        osc_run = 1'b0;
        MONITOR_EN_I = 1'b1;
        fire(0);
        wait_rel(n);
        n = 0;
        while (OSC_FAIL_TRAP_O !== 1'b1 && n < 60)
        begin
            cy(1);
            n++;
        end
        chk_time(n, HOLD + 1, 3);
        chk({CLK_VALID_O, CLK_SEL_O}, 16'h0008);
        osc_run = 1'b1;
        $display("fail-safe test done");
        // Wake with regulator on, then off
        cy(3);
        WAKE_I = 1'b1;
        cy(1);
        WAKE_I = 1'b0;
        cy(2);
        chk({SYSTEM_RESET_O, EXEC_EN_O}, 16'h0000);
        n = 2;
        while (EXEC_EN_O !== 1'b1 && n < 5000)
        begin
            cy(1);
            n++;
        end
        chk_time(n, TS + 1, 3);
        REG_EN_I = 1'b0;
        WAKE_I = 1'b1;
        cy(1);
        WAKE_I = 1'b0;
        cy(3);
        chk(EXEC_EN_O, 1'b1);
        CAUSE_WE_I = 1'b1;
        CAUSE_WDATA_I = 16'h00d0;
        cy(1);
        CAUSE_WE_I = 1'b0;
        cy(1);
        chk(RESET_CAUSE_O, 16'h00d0);
        // Watchdog set and software clear meet in one cycle: set wins
        CAUSE_WDATA_I = 16'h0000;
        CAUSE_WE_I = 1'b1;
        fire(3);
        CAUSE_WE_I = 1'b0;
        cy(1);
        chk(RESET_CAUSE_O, 16'h0010);
        SRST_I = 1'b1;
        cy(2);
        chk({SYSTEM_RESET_O, EXEC_EN_O}, 16'h0002);
        chk(RESET_CAUSE_O, 16'h0003);
        $display("wake and reset tests done");
        close_out();
    end
endmodule : test_rds_sequencer
